// [design/wake_defs.svh]
`ifndef WAKE_DEFS_SVH
`define WAKE_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices; byte address is index times four
`define WAKE_IDX_STATUS_ONE 6'h04
`define WAKE_IDX_STATUS_FIVE 6'h08
`define WAKE_IDX_RESERVED 6'h09
`define WAKE_IDX_ENABLE_ONE 6'h0a
`define WAKE_IDX_ENABLE_FIVE 6'h0e
`define WAKE_IDX_GLOBAL 6'h10
`define WAKE_IDX_PENDING 6'h11
`define WAKE_IDX_SOURCE 6'h12

// Word index field of the byte address
`define WAKE_ADDR_IDX_MSB 7
`define WAKE_ADDR_IDX_LSB 2

////////////////////////////////////////////////////////////////////////////////
// Reset values, applied only by the standby-supply power-on reset
`define WAKE_STATUS_RESET 8'h00
`define WAKE_ENABLE_RESET 8'h00
`define WAKE_GLOBAL_RESET 1'b0
`define WAKE_RDATA_RESET 32'h0000_0000
`define WAKE_REQ_N_RESET 1'b1

////////////////////////////////////////////////////////////////////////////////
// Field positions of status and enable register one
`define WAKE_ONE_RSVD_BIT 0
`define WAKE_ONE_RING_TWO_BIT 1
`define WAKE_ONE_RING_ONE_BIT 2
`define WAKE_ONE_KEYBOARD_BIT 3
`define WAKE_ONE_MOUSE_BIT 4
`define WAKE_ONE_SPECIFIC_KEY_BIT 5
`define WAKE_ONE_FAN_ONE_BIT 6
`define WAKE_ONE_FAN_TWO_BIT 7
`define WAKE_ONE_USED_MASK 8'hfe

// Global enable bit and pending-view layout
`define WAKE_GLOBAL_BIT 0
`define WAKE_PEND_ONE_LSB 0
`define WAKE_PEND_FIVE_LSB 8
`define WAKE_PEND_ANY_BIT 16
`define WAKE_SRC_ONE_LSB 0
`define WAKE_SRC_FIVE_LSB 8

`endif

// [design/wake_pkg.sv]
package wake_pkg;

  // One wake register byte
  typedef logic [7:0] wake_byte_t;
  // APB data word
  typedef logic [31:0] apb_word_t;
  // APB byte address
  typedef logic [7:0] apb_addr_t;
  // Register word index
  typedef logic [5:0] reg_index_t;

endpackage : wake_pkg

// [design/wake_event_status_enable.sv]
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "wake_defs.svh"

module wake_event_status_enable (
  // Clock and standby-supply power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire wake_pkg::apb_addr_t paddr,
  input wire wake_pkg::apb_word_t pwdata,
  input wire logic [3:0] pstrb,
  output var wake_pkg::apb_word_t prdata,
  output logic pready,
  output var logic pslverr,
  // Wake sources of group one
  input wire logic ring_indicator_two,
  input wire logic ring_indicator_one,
  input wire logic keyboard_wake,
  input wire logic mouse_wake,
  input wire logic specific_key_wake,
  input wire logic fan_speed_one_wake,
  input wire logic fan_speed_two_wake,
  // Wake sources gpio_five_zero .. gpio_five_seven
  input wire wake_pkg::wake_byte_t gpio_wake,
  // Shared wake request, active low
  output var logic wake_request_out_n
);
  import wake_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Register map, one byte per word in byte lane 0, except the pending and source views, which are wider
  //   idx 04 status one, write one to clear
  //   idx 08 status five, write one to clear
  //   idx 09 reserved, reads zero, writes dropped
  //   idx 0a enable one, bit 0 not stored
  //   idx 0e enable five, gates status five
  //   idx 10 global enable in bit 0
  //   idx 11 pending view, read only
  //   idx 12 live source view, read only
  // Other words answer with pslverr and zero data
  //
  // Group one layout, shared by status one and enable one
  //   bit 0 reserved, never set and never stored
  //   bit 1 ring_indicator_two
  //   bit 2 ring_indicator_one
  //   bit 3 keyboard_wake
  //   bit 4 mouse_wake
  //   bit 5 specific_key_wake
  //   bit 6 fan_speed_one_wake
  //   bit 7 fan_speed_two_wake
  //
  // Pending view: [7:0] group one, [15:8] group five, [16] combined request
  // Source view: [7:0] group one levels, [15:8] gpio levels
  //
  // Bus timing, zero wait states
  //   setup edge: read data and error flag loaded
  //   access edge: write lands, master takes read data
  //   read data and error stand until the next setup edge
  //   pstrb[0] low drops a write silently
  //
  // Limitation: presetn is the only reset, so every bit lives in the
  // standby domain; main-supply, soft and hard resets are not inputs
  // Trade-off: zero wait states, so read data is fetched at the setup edge

  //////////////////////////////////////////////////////////////////////////////
  // Storage
  wake_byte_t wake_status_one;
  wake_byte_t wake_status_five;
  wake_byte_t wake_enable_one;
  wake_byte_t wake_enable_five;
  logic global_wake_enable;
  wake_byte_t next_status_one;
  wake_byte_t next_status_five;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire reg_index_t reg_index;
  wire logic setup_phase;
  wire logic access_phase;
  wire logic write_fire;
  wire wake_byte_t write_byte;
  wire logic hit_status_one;
  wire logic hit_status_five;
  wire logic hit_reserved;
  wire logic hit_enable_one;
  wire logic hit_enable_five;
  wire logic hit_global;
  wire logic hit_pending;
  wire logic hit_source;
  wire logic hit_any;
  // Per-register write strobes
  wire logic write_status_one;
  wire logic write_status_five;
  wire logic write_enable_one;
  wire logic write_enable_five;
  wire logic write_global;

  // Zero-wait slave: read data is captured in the setup cycle
  assign reg_index = paddr[`WAKE_ADDR_IDX_MSB:`WAKE_ADDR_IDX_LSB];
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  // Registers sit in byte lane 0, so only that strobe lets a write through
  assign write_fire = access_phase & pwrite & pstrb[0];
  assign write_byte = pwdata[7:0];
  assign pready = 1'b1;

  // Address hits
  assign hit_status_one = (reg_index == `WAKE_IDX_STATUS_ONE);
  assign hit_status_five = (reg_index == `WAKE_IDX_STATUS_FIVE);
  assign hit_reserved = (reg_index == `WAKE_IDX_RESERVED);
  assign hit_enable_one = (reg_index == `WAKE_IDX_ENABLE_ONE);
  assign hit_enable_five = (reg_index == `WAKE_IDX_ENABLE_FIVE);
  assign hit_global = (reg_index == `WAKE_IDX_GLOBAL);
  assign hit_pending = (reg_index == `WAKE_IDX_PENDING);
  assign hit_source = (reg_index == `WAKE_IDX_SOURCE);
  assign hit_any = hit_status_one | hit_status_five | hit_reserved | hit_enable_one |
                   hit_enable_five | hit_global | hit_pending | hit_source;

  // Read-only and reserved words get no strobe, so writes there land nowhere
  assign write_status_one = write_fire & hit_status_one;
  assign write_status_five = write_fire & hit_status_five;
  assign write_enable_one = write_fire & hit_enable_one;
  assign write_enable_five = write_fire & hit_enable_five;
  assign write_global = write_fire & hit_global;

  //////////////////////////////////////////////////////////////////////////////
  // Source vectors
  wire wake_byte_t source_one;
  wire wake_byte_t source_five;
  wire wake_byte_t clear_one;
  wire wake_byte_t clear_five;

  // Group one packed in the enable-one layout; reserved bit never fires
  assign source_one[`WAKE_ONE_RSVD_BIT] = 1'b0;
  assign source_one[`WAKE_ONE_RING_TWO_BIT] = ring_indicator_two;
  assign source_one[`WAKE_ONE_RING_ONE_BIT] = ring_indicator_one;
  assign source_one[`WAKE_ONE_KEYBOARD_BIT] = keyboard_wake;
  assign source_one[`WAKE_ONE_MOUSE_BIT] = mouse_wake;
  assign source_one[`WAKE_ONE_SPECIFIC_KEY_BIT] = specific_key_wake;
  assign source_one[`WAKE_ONE_FAN_ONE_BIT] = fan_speed_one_wake;
  assign source_one[`WAKE_ONE_FAN_TWO_BIT] = fan_speed_two_wake;
  // Sources are taken as synchronous; pins need synchronising upstream
  // Bit n of gpio_wake is pin 5n
  assign source_five = gpio_wake;

  // Write-one-to-clear masks; zeros written clear nothing
  assign clear_one = write_status_one ? write_byte : 8'h00;
  assign clear_five = write_status_five ? write_byte : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status latches, one per bit
  // A source held high keeps re-setting its bit, so a clear only sticks
  // once the source has dropped; software clears, then re-reads
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_status
      // Set beats clear, so an event in the clearing cycle is kept
      assign next_status_one[g] = source_one[g] | (wake_status_one[g] & ~clear_one[g]);
      assign next_status_five[g] = source_five[g] | (wake_status_five[g] & ~clear_five[g]);
    end
  endgenerate

  // Only presetn clears; main-supply, soft and hard resets never reach here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_status_one <= `WAKE_STATUS_RESET;
      wake_status_five <= `WAKE_STATUS_RESET;
    end else begin
      wake_status_one <= next_status_one;
      wake_status_five <= next_status_five;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Enable registers and global enable
  // Enable one; reserved bit 0 is not stored, so it always reads zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_enable_one <= `WAKE_ENABLE_RESET;
    end else if (write_enable_one) begin
      wake_enable_one <= write_byte & `WAKE_ONE_USED_MASK;
    end
  end

  // Enable five gates status five; its word index is a local choice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_enable_five <= `WAKE_ENABLE_RESET;
    end else if (write_enable_five) begin
      wake_enable_five <= write_byte;
    end
  end

  // Global enable starts off, so nothing wakes before software opts in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_wake_enable <= `WAKE_GLOBAL_RESET;
    end else if (write_global) begin
      global_wake_enable <= write_byte[`WAKE_GLOBAL_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wake request gating
  wire wake_byte_t pending_one;
  wire wake_byte_t pending_five;
  wire logic pending_any;
  wire logic any_one;
  wire logic any_five;

  // Disabled sources stay visible in status yet are masked here
  assign pending_one = wake_status_one & wake_enable_one;
  assign pending_five = wake_status_five & wake_enable_five;
  // With global enable set, either group alone is enough to pull the request
  assign any_one = |pending_one;
  assign any_five = |pending_five;
  assign pending_any = global_wake_enable & (any_one | any_five);

  // Registered so the pin never glitches while status bits change
  // Costs one cycle between a status or enable change and the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request_out_n <= `WAKE_REQ_N_RESET;
    end else begin
      wake_request_out_n <= ~pending_any;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data selection
  wire apb_word_t word_status_one;
  wire apb_word_t word_status_five;
  wire apb_word_t word_enable_one;
  wire apb_word_t word_enable_five;
  wire apb_word_t word_global;
  wire apb_word_t word_pending;
  wire apb_word_t word_source;
  wire apb_word_t word_reserved;
  wire apb_word_t read_word;
  wire apb_word_t next_prdata;
  wire logic next_pslverr;

  assign word_status_one = {24'h00_0000, wake_status_one};
  assign word_status_five = {24'h00_0000, wake_status_five};
  assign word_enable_one = {24'h00_0000, wake_enable_one};
  assign word_enable_five = {24'h00_0000, wake_enable_five};
  assign word_global = {31'h0000_0000, global_wake_enable};
  // Pending view: enabled-and-set bits plus the combined request
  assign word_pending = {15'h0000, pending_any, pending_five, pending_one};
  // Live source levels, handy to see what is still holding a bit set
  assign word_source = {16'h0000, source_five, source_one};

  // Reserved word is all zero; its writes have no strobe to land on
  assign word_reserved = `WAKE_RDATA_RESET;

  // Reserved location and unmapped space both read zero
  assign read_word = hit_status_one ? word_status_one :
                     hit_status_five ? word_status_five :
                     hit_reserved ? word_reserved :
                     hit_enable_one ? word_enable_one :
                     hit_enable_five ? word_enable_five :
                     hit_global ? word_global :
                     hit_pending ? word_pending :
                     hit_source ? word_source :
                     `WAKE_RDATA_RESET;

  // Writes return zero data; every unmapped word raises an error
  assign next_prdata = pwrite ? `WAKE_RDATA_RESET : read_word;
  assign next_pslverr = ~hit_any;

  // Captured in setup, held through access and after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `WAKE_RDATA_RESET;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule : wake_event_status_enable

`default_nettype wire

// [dv/wake_event_status_enable_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module wake_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire wake_pkg::apb_addr_t paddr,
  input wire wake_pkg::apb_word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Wake side
  input wire wake_pkg::wake_byte_t gpio_wake,
  input wire logic wake_request_out_n
);
  import wake_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Setup phase decode; data is loaded at this edge
  wire logic setup = psel & ~penable;
  wire logic rd_setup = setup & ~pwrite;
  wire reg_index_t idx = paddr[7:2];
  wire logic mapped = idx inside {6'h04, 6'h08, 6'h09, 6'h0a, 6'h0e, 6'h10, 6'h11, 6'h12};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  ready_high_a: assert property (pready) else $error("pready low");
  err_unmapped_a: assert property (setup && !mapped |=> pslverr) else $error("no error on unmapped");
  err_mapped_a: assert property (setup && mapped |=> !pslverr) else $error("error on mapped word");
  rdata_hold_a: assert property (!setup |=> $stable(prdata)) else $error("read data moved");
  rsvd_zero_a: assert property (rd_setup && idx == 6'h09 |=> prdata == 32'h0)
    else $error("reserved word not zero");
  one_layout_a: assert property (rd_setup && idx == 6'h04 |=> prdata[0] == 1'b0)
    else $error("status one bit zero set");
  enable_layout_a: assert property (rd_setup && idx == 6'h0a |=> prdata[0] == 1'b0)
    else $error("enable one bit zero set");
  // Event two edges back must show; older reset edges excluded
  gpio_sticky_a: assert property (rd_setup && idx == 6'h08 |=> !$past(presetn, 2) ||
    (prdata[7:0] & $past(gpio_wake, 2)) == $past(gpio_wake, 2)) else $error("gpio event lost");
  pend_req_a: assert property (rd_setup && idx == 6'h11 |=> prdata[16] == !wake_request_out_n)
    else $error("request differs from pending");
endmodule : wake_checker
bind wake_event_status_enable wake_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .gpio_wake, .wake_request_out_n);
`default_nettype wire

// [dv/wake_sink_model.sv]
`timescale 1ns/1ps
`default_nettype none
module wake_sink_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request and what the chipset saw
  input wire logic wake_request_out_n,
  output logic seen
);
  // Any low level counts as a wake; the chipset keeps it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= 1'b0;
    end else if (!wake_request_out_n) begin
      seen <= 1'b1;
    end
  end
endmodule : wake_sink_model
`default_nettype wire

// [dv/wake_event_status_enable_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module wake_event_status_enable_tb;
  import wake_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, req_n, seen, err;
  apb_addr_t paddr = 8'h00;
  apb_word_t pwdata = 32'h0, prdata, rd;
  logic [7:1] src = 7'h00;
  logic [3:0] pstrb = 4'hf, strb = 4'hf;
  wake_byte_t gpio_wake = 8'h00;
  int num_errors = 0, cmp_count = 0;
  wake_event_status_enable dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ring_indicator_two(src[1]), .ring_indicator_one(src[2]), .keyboard_wake(src[3]),
    .mouse_wake(src[4]), .specific_key_wake(src[5]), .fan_speed_one_wake(src[6]),
    .fan_speed_two_wake(src[7]), .gpio_wake(gpio_wake), .wake_request_out_n(req_n));
  wake_sink_model sink_u (.pclk(pclk), .presetn(presetn), .wake_request_out_n(req_n), .seen(seen));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare, count, report
  task automatic chk(input string what, input apb_word_t exp, input apb_word_t got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; held until pready is seen at an edge
  task automatic xfer(input logic w, input apb_addr_t a, input wake_byte_t d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rdchk(input string what, input apb_addr_t a, input apb_word_t exp);
    xfer(1'b0, a, 8'h00);
    chk(what, exp, rd);
  endtask : rdchk
  // One-cycle event on the sources
  task automatic pulse(input logic [7:1] s, input wake_byte_t g);
    @(posedge pclk);
    src <= s;
    gpio_wake <= g;
    @(posedge pclk);
    src <= 7'h00;
    gpio_wake <= 8'h00;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("status_one", 8'h10, 32'h0);
    rdchk("status_five", 8'h20, 32'h0);
    rdchk("enable_one", 8'h28, 32'h0);
    xfer(1'b1, 8'h24, 8'hff);
    rdchk("reserved", 8'h24, 32'h0);
    chk("reserved_err", 32'h0, {31'h0, err});
    xfer(1'b0, 8'h4c, 8'h00);
    chk("unmapped_err", 32'h1, {31'h0, err});
    $display("test registers done");
    pulse(7'h00, 8'ha5);
    rdchk("gpio_status", 8'h20, 32'ha5);
    xfer(1'b1, 8'h20, 8'h81);
    rdchk("gpio_w1c", 8'h20, 32'h24);
    // Every group-one source lands on its own bit
    for (int i = 1; i < 8; i++) begin
      pulse(7'(1 << (i - 1)), 8'h00);
      rdchk("status_one", 8'h10, 32'(1 << i));
      xfer(1'b1, 8'h10, 8'hff);
    end
    $display("test status done");
    pulse(7'h04, 8'h00);
    xfer(1'b1, 8'h40, 8'h01);
    repeat (2) @(posedge pclk);
    #1;
    chk("req_disabled", 32'h1, {31'h0, req_n});
    xfer(1'b1, 8'h28, 8'hff);
    rdchk("enable_one", 8'h28, 32'hfe);
    rdchk("pending", 8'h44, 32'h0001_0008);
    #1;
    chk("req_enabled", 32'h0, {31'h0, req_n});
    chk("chipset_seen", 32'h1, {31'h0, seen});
    xfer(1'b1, 8'h10, 8'h08);
    repeat (2) @(posedge pclk);
    #1;
    chk("req_released", 32'h1, {31'h0, req_n});
    $display("test request done");
    // Enable five: a write without the lane 0 strobe is dropped
    strb = 4'he;
    xfer(1'b1, 8'h38, 8'h04);
    strb = 4'hf;
    rdchk("enable_five_strb", 8'h38, 32'h0);
    xfer(1'b1, 8'h38, 8'h04);
    rdchk("enable_five", 8'h38, 32'h04);
    rdchk("pending_five", 8'h44, 32'h0001_0400);
    rdchk("global", 8'h40, 32'h1);
    #1;
    chk("req_five", 32'h0, {31'h0, req_n});
    // Held sources show live and beat a clear in the same cycle
    @(posedge pclk);
    src <= 7'h40;
    gpio_wake <= 8'h80;
    rdchk("source_view", 8'h48, 32'h0000_8080);
    xfer(1'b1, 8'h20, 8'h80);
    rdchk("set_wins", 8'h20, 32'ha4);
    @(posedge pclk);
    src <= 7'h00;
    gpio_wake <= 8'h00;
    xfer(1'b1, 8'h20, 8'h80);
    rdchk("clear_after", 8'h20, 32'h24);
    $display("test views done");
    // Standby reset in mid-run clears status and enables alike
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("status_five_rst", 8'h20, 32'h0);
    rdchk("enable_one_rst", 8'h28, 32'h0);
    rdchk("enable_five_rst", 8'h38, 32'h0);
    chk("req_rst", 32'h1, {31'h0, req_n});
    chk("chipset_rst", 32'h0, {31'h0, seen});
    $display("test reset done");
    report_and_stop();
  end
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // Watchdog at 5000 cycles, far beyond the fewer than two hundred needed
  initial begin
    #25000;
    num_errors++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
endmodule : wake_event_status_enable_tb
`default_nettype wire
